// ### include/uic_params.svh
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH

// ============================================================
// Bus geometry
`define UIC_AW            4
`define UIC_DW            8
`define UIC_EVW           3

// ============================================================
// Register offsets
`define UIC_OFF_IDCTL     4'h2
`define UIC_OFF_STAT      4'h8
`define UIC_OFF_MASK      4'h9

// ============================================================
// Shared register fields
`define UIC_BIT_QEN       0
`define UIC_BIT_RXRST     1
`define UIC_BIT_TXRST     2
`define UIC_ID_LSB        0
`define UIC_ID_MSB        3
`define UIC_ENR_LSB       6
`define UIC_ENR_MSB       7
`define UIC_ENR_ON        2'h3
`define UIC_ENR_OFF       2'h0

// ============================================================
// Identification codes
`define UIC_ID_NONE       4'h1
`define UIC_ID_THRE       4'h2
`define UIC_ID_RXDATA     4'h4
`define UIC_ID_LINE       4'h6
`define UIC_ID_BUSY       4'h7
`define UIC_ID_TIMEOUT    4'hC
`define UIC_ID_MODEM      4'h0

// ============================================================
// Status event bits
`define UIC_EV_TXRST      0
`define UIC_EV_RXRST      1
`define UIC_EV_PEND       2

// ============================================================
// Reset values
`define UIC_RST_DATA      8'h00
`define UIC_RST_EV        3'h0
`define UIC_RST_ID        4'h1

`endif

// ### include/uic_pkg.sv
`include "uic_params.svh"

package uic_pkg;

  // ==========================================================
  // Register state of the control block
  typedef struct packed {
    logic [`UIC_DW-1:0]  rdata;
    logic                txr;
    logic                rxr;
    logic                qen;
    logic [`UIC_EVW-1:0] stat;
    logic [`UIC_EVW-1:0] mask;
    logic                irq;
    logic                pend;
  } uic_state_s;

  typedef logic [3:0] uic_id_t;

endpackage : uic_pkg

// ### rtl/uic_ctrl.sv
// Operation
// RULE_01 - Read returns four-bit pending interrupt code
// RULE_02 - Transmit reset bit empties transmit queue logic
// RULE_03 - Receive reset bit empties receive queue logic
// RULE_04 - Both reset bits clear themselves
// RULE_05 - Enable bit switches both queues together
// RULE_06 - Enable change resets both queue controls
// RULE_07 - Priority: line, rx/timeout, tx empty, modem
// RULE_08 - After reset code reads no interrupt pending
//
// The plain strobed port and the placing of the registers were left to the implementer.

`include "uic_params.svh"

module uic_ctrl
  import uic_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Register port
  input  wire logic [`UIC_AW-1:0]  addr,
  input  wire logic [`UIC_DW-1:0]  wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output      logic [`UIC_DW-1:0]  rdata,
  // Pending interrupt sources
  input  wire logic                line_status_pend,
  input  wire logic                rx_data_pend,
  input  wire logic                char_timeout_pend,
  input  wire logic                tx_holding_empty_pend,
  input  wire logic                modem_pend,
  input  wire logic                busy_pend,
  // Queue control
  output      logic                tx_queue_reset,
  output      logic                rx_queue_reset,
  output      logic                queue_enable,
  // Interrupt
  output      logic                irq
);

  // ==========================================================
  // Identification
  uic_id_t     irq_ident_code;
  uic_state_s  st_r;
  uic_state_s  st_nxt;

  uic_prio u_prio (
    .line_status_pend      (line_status_pend),
    .rx_data_pend          (rx_data_pend),
    .char_timeout_pend     (char_timeout_pend),
    .tx_holding_empty_pend (tx_holding_empty_pend),
    .modem_pend            (modem_pend),
    .busy_pend             (busy_pend),
    .irq_ident_code        (irq_ident_code)
  );

  // ==========================================================
  // Address decode
  logic                wr_id;
  logic                wr_stat;
  logic                wr_mask;
  logic                rd_id;
  logic                rd_stat;
  logic                rd_mask;

  assign wr_id   = wr_en && (addr == `UIC_OFF_IDCTL);
  assign wr_stat = wr_en && (addr == `UIC_OFF_STAT);
  assign wr_mask = wr_en && (addr == `UIC_OFF_MASK);
  assign rd_id   = rd_en && (addr == `UIC_OFF_IDCTL);
  assign rd_stat = rd_en && (addr == `UIC_OFF_STAT);
  assign rd_mask = rd_en && (addr == `UIC_OFF_MASK);

  // ==========================================================
  // Event detection
  logic                en_chg;
  logic                now_pend;
  logic                tx_wr_req;
  logic                rx_wr_req;

  assign en_chg    = wr_id && (wdata[`UIC_BIT_QEN] != st_r.qen); // RULE_06
  assign now_pend  = (irq_ident_code != `UIC_ID_NONE); // RULE_08
  assign tx_wr_req = wr_id && wdata[`UIC_BIT_TXRST]; // RULE_02
  assign rx_wr_req = wr_id && wdata[`UIC_BIT_RXRST]; // RULE_03

  // ==========================================================
  // Next state
  always_comb begin
    logic [`UIC_EVW-1:0] ev_set;
    logic [`UIC_EVW-1:0] ev_clr;
    logic [`UIC_DW-1:0]  rd_word;
    ev_set  = `UIC_RST_EV;
    ev_clr  = `UIC_RST_EV;
    rd_word = `UIC_RST_DATA;
    st_nxt  = st_r;

    // Queue control, self-clearing strobes, one cycle per write
    st_nxt.txr = tx_wr_req || en_chg; // RULE_02 RULE_04 RULE_06
    st_nxt.rxr = rx_wr_req || en_chg; // RULE_03 RULE_04 RULE_06
    if (wr_id) begin
      st_nxt.qen = wdata[`UIC_BIT_QEN]; // RULE_05
    end

    // Mask register
    if (wr_mask) begin
      st_nxt.mask = wdata[`UIC_EVW-1:0];
    end

    // Write-one clear of status
    if (wr_stat) begin
      ev_clr = wdata[`UIC_EVW-1:0];
    end

    // Status events
    st_nxt.pend           = now_pend;
    ev_set[`UIC_EV_TXRST] = st_nxt.txr;
    ev_set[`UIC_EV_RXRST] = st_nxt.rxr;
    ev_set[`UIC_EV_PEND]  = now_pend && !st_r.pend;

    // Set wins over a write-one clear, bit by bit
    for (int i = 0; i < `UIC_EVW; i++) begin
      if (ev_set[i]) begin
        st_nxt.stat[i] = 1'h1;
      end else if (ev_clr[i]) begin
        st_nxt.stat[i] = 1'h0;
      end else begin
        st_nxt.stat[i] = st_r.stat[i];
      end
    end

    // Level interrupt from next status and mask
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    // Read mux, data valid only in the cycle after the strobe
    if (rd_id) begin
      rd_word[`UIC_ID_MSB:`UIC_ID_LSB] = irq_ident_code; // RULE_01 RULE_08
      if (st_r.qen) begin
        rd_word[`UIC_ENR_MSB:`UIC_ENR_LSB] = `UIC_ENR_ON;
      end else begin
        rd_word[`UIC_ENR_MSB:`UIC_ENR_LSB] = `UIC_ENR_OFF;
      end
    end else if (rd_stat) begin
      rd_word[`UIC_EVW-1:0] = st_r.stat;
    end else if (rd_mask) begin
      rd_word[`UIC_EVW-1:0] = st_r.mask;
    end else begin
      rd_word = `UIC_RST_DATA;
    end
    st_nxt.rdata = rd_word;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r.rdata <= `UIC_RST_DATA;
      st_r.txr   <= 1'b0;
      st_r.rxr   <= 1'b0;
      st_r.qen   <= 1'b0;
      st_r.stat  <= `UIC_RST_EV;
      st_r.mask  <= `UIC_RST_EV;
      st_r.irq   <= 1'b0;
      st_r.pend  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata          = st_r.rdata;
  assign tx_queue_reset = st_r.txr;
  assign rx_queue_reset = st_r.rxr;
  assign queue_enable   = st_r.qen;
  assign irq            = st_r.irq;

endmodule : uic_ctrl

// ### rtl/uic_prio.sv
`include "uic_params.svh"

// ============================================================
// Interrupt identification priority encoder
module uic_prio
  import uic_pkg::*;
(
  // Pending sources
  input  wire logic    line_status_pend,
  input  wire logic    rx_data_pend,
  input  wire logic    char_timeout_pend,
  input  wire logic    tx_holding_empty_pend,
  input  wire logic    modem_pend,
  input  wire logic    busy_pend,
  // Result
  output uic_id_t      irq_ident_code
);

  always_comb begin
    if (line_status_pend) begin
      irq_ident_code = `UIC_ID_LINE; // RULE_07
    end else if (rx_data_pend) begin
      irq_ident_code = `UIC_ID_RXDATA; // RULE_07
    end else if (char_timeout_pend) begin
      irq_ident_code = `UIC_ID_TIMEOUT; // RULE_07
    end else if (tx_holding_empty_pend) begin
      irq_ident_code = `UIC_ID_THRE; // RULE_07
    end else if (modem_pend) begin
      irq_ident_code = `UIC_ID_MODEM; // RULE_07
    end else if (busy_pend) begin
      irq_ident_code = `UIC_ID_BUSY; // RULE_01
    end else begin
      irq_ident_code = `UIC_ID_NONE; // RULE_01 RULE_08
    end
  end

endmodule : uic_prio

// ### tb/tb_uic_ctrl.sv
`include "uic_params.svh"
module tb_uic_ctrl
  import uic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [5:0] src = 6'h00;
  logic       tx_queue_reset, rx_queue_reset, queue_enable, irq;
  int         err_count = 0, checks = 0, cyc = 0;
  logic [5:0] srcs [7] = '{6'h01, 6'h02, 6'h06, 6'h0E, 6'h1E, 6'h3F, 6'h00};
  uic_id_t    ids [7] = '{`UIC_ID_BUSY, `UIC_ID_MODEM, `UIC_ID_THRE,
    `UIC_ID_TIMEOUT, `UIC_ID_RXDATA, `UIC_ID_LINE, `UIC_ID_NONE};
  uic_ctrl uic_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .line_status_pend(src[5]), .rx_data_pend(src[4]),
    .char_timeout_pend(src[3]), .tx_holding_empty_pend(src[2]),
    .modem_pend(src[1]), .busy_pend(src[0]), .irq(irq),
    .tx_queue_reset(tx_queue_reset), .rx_queue_reset(rx_queue_reset),
    .queue_enable(queue_enable));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk_sys);
    wr_en <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk_sys);
    rd_en <= 1'h0;
    #1;
    cmp("rdata", e, rdata);
  endtask : rd
  task automatic cq(logic [7:0] e);
    cmp("queue", e, {5'h00, tx_queue_reset, rx_queue_reset, queue_enable});
  endtask : cq
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    rd(`UIC_OFF_IDCTL, 8'h01);
    for (int i = 0; i < 7; i++) begin
      src <= srcs[i];
      rd(`UIC_OFF_IDCTL, {4'h0, ids[i]});
    end
    wr(`UIC_OFF_IDCTL, 8'h07);
    cq(8'h07);
    @(posedge clk_sys);
    #1;
    cq(8'h01);
    rd(`UIC_OFF_IDCTL, 8'hC1);
    wr(`UIC_OFF_IDCTL, 8'h05);
    cq(8'h05);
    wr(`UIC_OFF_IDCTL, 8'h00);
    cq(8'h06);
    wr(`UIC_OFF_MASK, 8'h01);
    cmp("irq", 8'h01, {7'h00, irq});
    wr(`UIC_OFF_STAT, 8'h01);
    cmp("irq", 8'h00, {7'h00, irq});
    rd(`UIC_OFF_STAT, 8'h06);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    rd(`UIC_OFF_IDCTL, 8'h01);
    report_and_stop();
  end
endmodule : tb_uic_ctrl

// ### tb/uic_checker.sv
`include "uic_params.svh"
// ==========
// Port checker
module uic_checker
  import uic_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // Register port
  input wire logic [3:0]   addr,
  input wire logic [7:0]   wdata,
  input wire logic         wr_en,
  input wire logic         rd_en,
  input wire logic [7:0]   rdata,
  // Sources and outputs
  input wire logic         line_status_pend,
  input wire logic         tx_queue_reset,
  input wire logic         rx_queue_reset,
  input wire logic         queue_enable
);
  wire sel = addr == `UIC_OFF_IDCTL;
  wire w   = wr_en && sel;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_read_window: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("rdata outside read slot");
  a_line_first: assert property (rd_en && sel && line_status_pend
    |=> rdata[3:0] == `UIC_ID_LINE) else $error("line code not first");
  a_tx_reset: assert property (w && wdata[2] |=> tx_queue_reset)
    else $error("tx reset missing");
  a_rx_reset: assert property (w && wdata[1] |=> rx_queue_reset)
    else $error("rx reset missing");
  a_reset_cause: assert property (tx_queue_reset |-> $past(w))
    else $error("tx reset without write");
  a_self_clear: assert property (tx_queue_reset || rx_queue_reset
    |=> !tx_queue_reset && !rx_queue_reset) else $error("reset held");
  a_enable_set: assert property (w |=> queue_enable == $past(wdata[0]))
    else $error("enable not taken");
  a_enable_hold: assert property (!w |=> $stable(queue_enable))
    else $error("enable moved");
  a_change_resets: assert property (w && wdata[0] != queue_enable
    |=> tx_queue_reset && rx_queue_reset) else $error("no reset on change");
  cover property (w && wdata[0]);
  cover property (rd_en && sel && line_status_pend);
  cover property (w && wdata[2] && queue_enable);
endmodule : uic_checker

bind uic_ctrl uic_checker uic_checker_inst (.clk_sys(clk_sys), .rst(rst),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .line_status_pend(line_status_pend), .tx_queue_reset(tx_queue_reset),
  .rx_queue_reset(rx_queue_reset), .queue_enable(queue_enable));
